// ---- verilog/scf_pkg.sv ----
// Constants and types for the SPI command frame block
`default_nettype none
package scf_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam int OP_HI = 15;
  localparam int OP_LO = 14;
  localparam int ADDR_HI = 13;
  localparam int ADDR_LO = 9;
  localparam int PN_BIT = 8;
  localparam int DATA_HI = 7;
  localparam int DATA_LO = 0;
  localparam int ADDR_W = 5;
  localparam int NUM_REGS = 20;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] LAST_ADDR = 5'h13;
  typedef enum logic [1:0] {
    SCF_OP_READ = 2'h0,
    SCF_OP_WRITE = 2'h1,
    SCF_OP_RSVD = 2'h2,
    SCF_OP_FLAGS = 2'h3
  } scf_op_t;
endpackage
`default_nettype wire

// ---- verilog/scf_link.sv ----
// Link-clock side: shifts one 16-bit frame in and the response out
`timescale 1ns/1ps
`default_nettype none
module scf_link (
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  input wire logic [15:0] tx_word,
  output logic [15:0] rx_word_q,
  output logic done_tgl_q
);
  import scf_pkg::*;
  logic [14:0] sh_q;
  logic [4:0] cnt_q;
  logic [15:0] tx_q;

  // Count restarts from the frame's own select; link clock may stop between frames
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= 5'h00;
    end else if (cnt_q != FRAME_LEN) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_ff @(posedge spi_clk) begin
    if (cnt_q < FRAME_LEN) begin
      sh_q <= {sh_q[13:0], mosi};
    end
  end

  // Level raised by the 16th edge, cleared by deselect, so a cut frame never raises it
  always_ff @(posedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      done_tgl_q <= 1'b0;
    end else if (cnt_q == FRAME_LEN - 5'h01) begin
      done_tgl_q <= 1'b1;
    end
  end

  always_ff @(posedge spi_clk) begin
    if (cnt_q == FRAME_LEN - 5'h01) begin
      rx_word_q <= {sh_q, mosi};
    end
  end

  // Falling-edge launch; bit 15 goes out from select, the first fall loads bit 14 on
  always_ff @(negedge spi_clk or posedge cs_n) begin
    if (cs_n) begin
      tx_q <= 16'h0000;
    end else if (cnt_q == 5'h01) begin
      tx_q <= {tx_word[14:0], 1'b0};
    end else begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  assign miso = (cnt_q == 5'h00) ? tx_word[FRAME_BITS-1] : tx_q[FRAME_BITS-1];
  assign miso_oe_n = cs_n;
endmodule
`default_nettype wire

// ---- verilog/scf_core.sv ----
// SPI command frame decoder with register file, status and flag returns
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - One 16-bit frame per select low
// - Bits 15:14 select operation
// - Bits 13:9 are register address
// - 00 read, 01 write, 11 flags, 10 reserved
// - Write bit 8 is optional parity
// - Bit 8 one means parity one
// - Bits 7:0 are write payload
// - Upper response byte is fixed status
// - Write returns fixed plus extended status
// - Read returns status plus register content
// - No daisy-chain pass-through
// - Every register reads back
// - Some registers return flags
// - Missed write completes on next frame; here nothing commits late, pend_q only marks each committed write
// - Only writes affected, reads normal
module scf_core (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  input wire logic [7:0] fixed_status_bits,
  input wire logic [7:0] ext_status,
  input wire logic [scf_pkg::NUM_REGS-1:0] flag_capable,
  input wire logic [7:0] flag_bits [scf_pkg::NUM_REGS],
  output logic [7:0] reg_out [scf_pkg::NUM_REGS],
  output logic wr_strobe,
  output logic [scf_pkg::ADDR_W-1:0] wr_addr_q,
  output logic wr_parity_q,
  output logic flag_read_strobe,
  output logic [scf_pkg::ADDR_W-1:0] flag_addr_q
);
  import scf_pkg::*;
  logic [15:0] rx_word;
  logic done_tgl;
  logic [2:0] tgl_sync_q;
  logic cs_m_q;
  logic cs_s_q;
  logic frame_done;
  logic [15:0] word_q;
  logic [15:0] tx_d;
  logic [15:0] tx_q;
  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] last_rd_q;
  logic [ADDR_W-1:0] addr_sel_q;
  logic op_rd_q;
  scf_op_t op;
  logic [ADDR_W-1:0] addr;
  logic [7:0] payload;
  logic pend_q;
  logic wr_fire;
  logic flag_fire;
  logic [7:0] rd_data;
  logic [7:0] flag_data;

  scf_link u_link (
    .spi_clk(spi_clk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe_n(miso_oe_n),
    .tx_word(tx_q),
    .rx_word_q(rx_word),
    .done_tgl_q(done_tgl)
  );

  // Done level crossing; the frame word stays put until the next frame's last edge
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tgl_sync_q <= 3'h0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], done_tgl};
    end
  end
  assign frame_done = tgl_sync_q[1] & ~tgl_sync_q[2];

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
    end else begin
      cs_m_q <= cs_n;
      cs_s_q <= cs_m_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      word_q <= 16'h0000;
    end else if (frame_done) begin
      word_q <= rx_word;
    end
  end

  // Decode reads the link word directly; it is quasi-static once frame_done fires
  assign op = scf_op_t'(rx_word[OP_HI:OP_LO]);
  assign addr = rx_word[ADDR_HI:ADDR_LO];
  assign payload = rx_word[DATA_HI:DATA_LO];

  // Writes commit directly; the pending flag only marks each write and feeds no commit path
  assign wr_fire = frame_done && (op == SCF_OP_WRITE) && (addr <= LAST_ADDR);
  assign flag_fire = frame_done && (op == SCF_OP_FLAGS) && (addr <= LAST_ADDR);

  // Marks each committed write until the next frame_done that carries no valid write
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pend_q <= 1'b0;
    end else if (wr_fire) begin
      pend_q <= 1'b1;
    end else if (frame_done) begin
      pend_q <= 1'b0;
    end
  end

  generate
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          regs_q[i] <= REG_RESET;
        end else if (wr_fire && addr == ADDR_W'(i)) begin
          regs_q[i] <= payload;
        end
      end
      assign reg_out[i] = regs_q[i];
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_addr_q <= 5'h00;
      wr_parity_q <= 1'b0;
    end else if (wr_fire) begin
      wr_addr_q <= addr;
      wr_parity_q <= rx_word[PN_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_strobe <= 1'b0;
      flag_read_strobe <= 1'b0;
    end else begin
      wr_strobe <= wr_fire;
      flag_read_strobe <= flag_fire;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flag_addr_q <= 5'h00;
    end else if (flag_fire) begin
      flag_addr_q <= addr;
    end
  end

  // Previous frame's command selects this frame's low byte
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      addr_sel_q <= 5'h00;
      op_rd_q <= 1'b0;
      last_rd_q <= 8'h00;
    end else if (frame_done) begin
      addr_sel_q <= addr;
      op_rd_q <= (op == SCF_OP_READ) || (op == SCF_OP_FLAGS);
      last_rd_q <= {7'h00, op == SCF_OP_FLAGS};
    end
  end

  always_comb begin
    rd_data = 8'h00;
    flag_data = 8'h00;
    if (addr_sel_q <= LAST_ADDR) begin
      rd_data = regs_q[addr_sel_q];
      if (flag_capable[addr_sel_q]) begin
        flag_data = flag_bits[addr_sel_q];
      end
    end
  end

  always_comb begin
    tx_d = {fixed_status_bits, ext_status};
    if (op_rd_q) begin
      tx_d = {fixed_status_bits, last_rd_q[0] ? flag_data : rd_data};
    end
  end

  // Held while select is low so the link shifts a stable word
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tx_q <= 16'h0000;
    end else if (cs_s_q) begin
      tx_q <= tx_d;
    end
  end

  // Checks watch the registered outputs one cycle after the event that sets them
  // Frames lie many cycles apart, so every strobe is a single-cycle pulse
  property p_wr_strobe;
    @(posedge sys_clk) disable iff (!rstn)
    wr_fire |=> wr_strobe && wr_addr_q == word_q[ADDR_HI:ADDR_LO];
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe missing");

  property p_no_rsvd;
    @(posedge sys_clk) disable iff (!rstn)
    (frame_done && op == SCF_OP_RSVD) |=> !wr_strobe && !flag_read_strobe;
  endproperty
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved op acted");

  property p_reg_store;
    @(posedge sys_clk) disable iff (!rstn)
    wr_fire |=> regs_q[$past(addr)] == $past(payload);
  endproperty
  a_reg_store: assert property (p_reg_store) else $error("payload not stored");

  property p_par;
    @(posedge sys_clk) disable iff (!rstn)
    wr_fire |=> wr_parity_q == word_q[PN_BIT];
  endproperty
  a_par: assert property (p_par) else $error("parity wrong");

  property p_read_keep;
    @(posedge sys_clk) disable iff (!rstn)
    (frame_done && op != SCF_OP_WRITE) |=> !wr_strobe && !pend_q;
  endproperty
  a_read_keep: assert property (p_read_keep) else $error("read wrote");

  property p_status;
    @(posedge sys_clk) disable iff (!rstn)
    cs_s_q |=> tx_q[15:8] == $past(fixed_status_bits);
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");

  property p_wr_resp;
    @(posedge sys_clk) disable iff (!rstn)
    (cs_s_q && !op_rd_q) |=> tx_q[7:0] == $past(ext_status);
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("ext status wrong");

  property p_rd_resp;
    @(posedge sys_clk) disable iff (!rstn)
    (cs_s_q && op_rd_q && !last_rd_q[0]) |=> tx_q[7:0] == $past(rd_data);
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read data wrong");

  property p_flag;
    @(posedge sys_clk) disable iff (!rstn)
    flag_fire |=> flag_read_strobe && flag_addr_q == $past(addr);
  endproperty
  a_flag: assert property (p_flag) else $error("flag strobe");

  property p_pend;
    @(posedge sys_clk) disable iff (!rstn)
    wr_fire |=> pend_q && wr_strobe;
  endproperty
  a_pend: assert property (p_pend) else $error("write not completed");

  property p_flag_resp;
    @(posedge sys_clk) disable iff (!rstn)
    (cs_s_q && op_rd_q && last_rd_q[0]) |=> tx_q[7:0] == $past(flag_data);
  endproperty
  a_flag_resp: assert property (p_flag_resp) else $error("flag byte wrong");

  property p_tx_hold;
    @(posedge sys_clk) disable iff (!rstn)
    !cs_s_q |=> $stable(tx_q);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("response moved in frame");

  property p_bad_addr;
    @(posedge sys_clk) disable iff (!rstn)
    (frame_done && addr > LAST_ADDR) |=> !wr_strobe && !flag_read_strobe;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("bad address acted");

  property p_strobe_pulse;
    @(posedge sys_clk) disable iff (!rstn)
    wr_strobe |=> !wr_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("write strobe too long");

  property p_flag_pulse;
    @(posedge sys_clk) disable iff (!rstn)
    flag_read_strobe |=> !flag_read_strobe;
  endproperty
  a_flag_pulse: assert property (p_flag_pulse) else $error("flag strobe too long");

  property p_sel;
    @(posedge sys_clk) disable iff (!rstn)
    (frame_done && op == SCF_OP_READ) |=> op_rd_q && addr_sel_q == $past(addr);
  endproperty
  a_sel: assert property (p_sel) else $error("read select wrong");
endmodule
`default_nettype wire

// ---- sim/scf_master.sv ----
// SPI bus master model driving the command frame core
`timescale 1ns/1ps
`default_nettype none
module scf_master (
  output logic spi_clk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // Select rises once everything waits, so the link's select-driven clear takes effect
  initial begin
    spi_clk = 1'b0;
    mosi = 1'b1;
    #1 cs_n = 1'b1;
  end
  // Clock stands low between frames; n below 16 gives a cut-short frame
  task automatic xfer(input logic [15:0] cmd, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    mosi = cmd[15];
    #613;
    for (int i = 15; i > 15 - n; i--) begin
      mosi = cmd[i];
      #40 spi_clk = 1'b1;
      rx = {rx[14:0], miso};
      #40 spi_clk = 1'b0;
    end
    #4400;
    cs_n = 1'b1;
    // Deselected line must not keep showing the last bit
    mosi = ~mosi;
    #400;
  endtask
endmodule
`default_nettype wire

// ---- sim/sbc_spi_command_frame_tb_top.sv ----
// Self-checking bench for the SPI command frame core
`timescale 1ns/1ps
`default_nettype none
module sbc_spi_command_frame_tb_top;
  import scf_pkg::*;
  logic sys_clk, rstn, spi_clk, cs_n, mosi, miso, miso_oe_n;
  logic wr_strobe, wr_parity_q, flag_read_strobe;
  logic [7:0] fixed_status_bits, ext_status;
  logic [NUM_REGS-1:0] flag_capable;
  logic [7:0] flag_bits [NUM_REGS];
  logic [7:0] reg_out [NUM_REGS];
  logic [ADDR_W-1:0] wr_addr_q, flag_addr_q;
  logic [15:0] rx;
  int n_fail = 0;
  int total_checks = 0;
  int n_wr = 0;
  int n_fr = 0;
  scf_core uut (.sys_clk(sys_clk), .rstn(rstn), .spi_clk(spi_clk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
    .fixed_status_bits(fixed_status_bits), .ext_status(ext_status),
    .flag_capable(flag_capable), .flag_bits(flag_bits), .reg_out(reg_out),
    .wr_strobe(wr_strobe), .wr_addr_q(wr_addr_q), .wr_parity_q(wr_parity_q),
    .flag_read_strobe(flag_read_strobe), .flag_addr_q(flag_addr_q));
  scf_master m (.spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Strobes stand one cycle, so they are counted rather than polled
  always @(posedge sys_clk) begin
    if (wr_strobe === 1'b1) n_wr <= n_wr + 1;
    if (flag_read_strobe === 1'b1) n_fr <= n_fr + 1;
  end
  function automatic logic [15:0] fr(logic [1:0] op, logic [4:0] a, logic p, logic [7:0] d);
    return {op, a, p, d};
  endfunction
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_write_read();
    int w0;
    w0 = n_wr;
    m.xfer(fr(SCF_OP_WRITE, 5'h05, 1'b1, 8'ha5), 16, rx);
    chk("miso_rst", rx, {fixed_status_bits, ext_status});
    chk("wr_count", 16'(n_wr - w0), 16'h0001);
    chk("reg5", {8'h00, reg_out[5]}, 16'h00a5);
    chk("wr_addr", {11'h000, wr_addr_q}, 16'h0005);
    chk("wr_par", {15'h0000, wr_parity_q}, 16'h0001);
    m.xfer(fr(SCF_OP_READ, 5'h05, 1'b1, 8'h00), 16, rx);
    chk("miso_wr", rx, {fixed_status_bits, ext_status});
    m.xfer(16'h2580, 16, rx);
    chk("miso_rd", rx, {fixed_status_bits, 8'ha5});
    $display("t_write_read done");
  endtask
  task automatic t_last_addr();
    m.xfer(fr(SCF_OP_WRITE, LAST_ADDR, 1'b0, 8'h5a), 16, rx);
    chk("reg19", {8'h00, reg_out[19]}, 16'h005a);
    chk("wr_par0", {15'h0000, wr_parity_q}, 16'h0000);
    chk("miso_oe", {15'h0000, miso_oe_n}, 16'h0001);
    $display("t_last_addr done");
  endtask
  task automatic t_flags();
    int f0;
    f0 = n_fr;
    m.xfer(fr(SCF_OP_FLAGS, 5'h10, 1'b1, 8'h00), 16, rx);
    chk("fr_count", 16'(n_fr - f0), 16'h0001);
    chk("fr_addr", {11'h000, flag_addr_q}, 16'h0010);
    m.xfer(16'h2580, 16, rx);
    chk("miso_flags", rx, {fixed_status_bits, 8'h3c});
    $display("t_flags done");
  endtask
  task automatic t_ignore();
    int w0;
    w0 = n_wr;
    m.xfer(fr(SCF_OP_RSVD, 5'h05, 1'b0, 8'h11), 16, rx);
    m.xfer(fr(SCF_OP_WRITE, 5'h05, 1'b0, 8'h22), 8, rx);
    m.xfer(fr(SCF_OP_WRITE, 5'h05, 1'b0, 8'h33), 15, rx);
    m.xfer(fr(SCF_OP_WRITE, 5'h1f, 1'b0, 8'h44), 16, rx);
    chk("ign_count", 16'(n_wr - w0), 16'h0000);
    chk("reg5_kept", {8'h00, reg_out[5]}, 16'h00a5);
    $display("t_ignore done");
  endtask
  initial begin
    #1ms;
    n_fail++;
    end_of_test();
  end
  initial begin
    rstn = 1'b0;
    fixed_status_bits = 8'hc3;
    ext_status = 8'h96;
    flag_capable = '0;
    flag_capable[16] = 1'b1;
    for (int i = 0; i < NUM_REGS; i++) flag_bits[i] = 8'h00;
    flag_bits[16] = 8'h3c;
    repeat (16) @(posedge sys_clk);
    #2 rstn = 1'b1;
    repeat (4) @(posedge sys_clk);
    #2;
    for (int i = 0; i < NUM_REGS; i++) chk("reg_rst", {8'h00, reg_out[i]}, {8'h00, REG_RESET});
    t_write_read();
    t_last_addr();
    t_flags();
    t_ignore();
    end_of_test();
  end
endmodule
`default_nettype wire
